// file: hw/wor_top.sv
// Notes on behaviour
// - each option word takes one write per reset; reads always allowed
// - reset clears every option bit except the trip level pair
// - trip level pair cleared and reopened only by power-on reset
// - option words decoded at indices 1E and 1F, plain latches
// - period select one gives short watchdog timeout, zero gives long
// - low-voltage guard off bit one disables the monitor
// - short stop recovery bit one gives 32 cycles, zero gives 4096
// - stop exit through reset pin always uses the long delay
// - stop enable zero makes the stop instruction an illegal opcode
// - watchdog off bit one disables the watchdog
// - pull-up off bit one disconnects the interrupt pin pull-up
// - stop oscillator off bit one halts the oscillator in stop
// - oscillator choice byte lives in flash, bus writes ignored
// - oscillator choice byte read after every power-on reset
// - select bit one means crystal, zero means RC; reset keeps it
// - crystal selected takes the shared pin away from port and key wake
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "wor_defines.svh"

module wor_top
	import wor_pkg::*;
(
	input  wire logic                      clk_in,
	input  wire logic                      reset_in,
	input  wire logic                      por_in,
	input  wire logic                      psel_in,
	input  wire logic                      penable_in,
	input  wire logic                      pwrite_in,
	input  wire logic [`WOR_ADDR_W-1:0]    paddr_in,
	input  wire logic [`WOR_DATA_W-1:0]    pwdata_in,
	input  wire logic [`WOR_BYTE_W-1:0]    flash_osc_byte_in,
	input  wire logic                      stop_exit_by_reset_in,
	output logic      [`WOR_DATA_W-1:0]    prdata_out,
	output logic                           pready_out,
	output logic                           pslverr_out,
	output logic                           watchdog_enable_out,
	output logic      [`WOR_WDOG_CNT_W-1:0] watchdog_period_out,
	output logic                           monitor_enable_out,
	output logic      [1:0]                trip_level_out,
	output logic      [`WOR_STOP_CNT_W-1:0] stop_recovery_out,
	output logic                           stop_instr_enable_out,
	output logic                           int_pin_pullup_out,
	output logic                           osc_halt_in_stop_out,
	output logic                           crystal_selected_out,
	output logic                           shared_pin_free_out
);
	// ==========================================================
	// address decode
	logic [`WOR_BYTE_W-1:0] index;
	logic                   word_aligned;
	logic                   hit_one;
	logic                   hit_two;
	logic                   hit_osc;
	logic                   hit_stat;
	logic                   mapped;
	logic                   access;
	wor_acc_t               acc_kind;

	assign index        = paddr_in[`WOR_BYTE_W+1:2];
	assign word_aligned = (paddr_in[1:0] == 2'h0) &&
	                      (paddr_in[`WOR_ADDR_W-1:`WOR_BYTE_W+2] == '0);
	assign hit_one      = word_aligned && (index == `WOR_IDX_OPT_ONE);
	assign hit_two      = word_aligned && (index == `WOR_IDX_OPT_TWO);
	assign hit_osc      = word_aligned && (index == `WOR_IDX_OSC_CHOICE);
	assign hit_stat     = word_aligned && (index == `WOR_IDX_STATUS);
	assign mapped       = hit_one || hit_two || hit_osc || hit_stat;

	// one wait state: pready rises in the second access cycle
	assign access   = psel_in && penable_in && pready_out;
	assign acc_kind = !access ? WOR_ACC_NONE : (pwrite_in ? WOR_ACC_WRITE : WOR_ACC_READ);

	// ==========================================================
	// option words
	logic [`WOR_BYTE_W-1:0] opt_one;
	logic [`WOR_BYTE_W-1:0] opt_two;
	logic                   one_written;
	logic                   two_written;
	logic                   trip_written;
	logic                   write_one;
	logic                   write_two;

	// writes to the choice byte and status word fall through: nothing latches
	assign write_one = (acc_kind == WOR_ACC_WRITE) && hit_one;
	assign write_two = (acc_kind == WOR_ACC_WRITE) && hit_two;

	wor_once_reg #(
		.WIDTH     (`WOR_BYTE_W),
		.USED_MASK (`WOR_ONE_MASK),
		.POR_MASK  (`WOR_RESET_BYTE)
	) u_opt_one (
		.clk_in          (clk_in),
		.reset_in        (reset_in),
		.por_in          (por_in),
		.write_in        (write_one),
		.wdata_in        (pwdata_in[`WOR_BYTE_W-1:0]),
		.value_out       (opt_one),
		.written_out     (one_written),
		.por_written_out ()
	);

	wor_once_reg #(
		.WIDTH     (`WOR_BYTE_W),
		.USED_MASK (`WOR_TWO_MASK),
		.POR_MASK  (`WOR_TWO_POR_ONLY_MASK)
	) u_opt_two (
		.clk_in          (clk_in),
		.reset_in        (reset_in),
		.por_in          (por_in),
		.write_in        (write_two),
		.wdata_in        (pwdata_in[`WOR_BYTE_W-1:0]),
		.value_out       (opt_two),
		.written_out     (two_written),
		.por_written_out (trip_written)
	);

	// ==========================================================
	// oscillator choice byte
	logic [`WOR_BYTE_W-1:0] osc_choice;
	wor_osc_t               osc_type;
	logic                   osc_valid;

	wor_osc_capture u_osc (
		.clk_in        (clk_in),
		.por_in        (por_in),
		.flash_byte_in (flash_osc_byte_in),
		.choice_out    (osc_choice),
		.osc_type_out  (osc_type),
		.valid_out     (osc_valid)
	);

	// ==========================================================
	// apb answer
	logic [`WOR_DATA_W-1:0] next_prdata;

	always_comb begin
		next_prdata = '0;
		if (hit_one) begin
			next_prdata[`WOR_BYTE_W-1:0] = opt_one;
		end else if (hit_two) begin
			next_prdata[`WOR_BYTE_W-1:0] = opt_two;
		end else if (hit_osc) begin
			next_prdata[`WOR_BYTE_W-1:0] = osc_choice;
		end else if (hit_stat) begin
			next_prdata[`WOR_STAT_ONE_WRITTEN]  = one_written;
			next_prdata[`WOR_STAT_TWO_WRITTEN]  = two_written;
			next_prdata[`WOR_STAT_TRIP_WRITTEN] = trip_written;
			next_prdata[`WOR_STAT_OSC_VALID]    = osc_valid;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || por_in) begin
			pready_out <= 1'b0;
		end else begin
			pready_out <= psel_in && penable_in && !pready_out;
		end
	end

	// data and error are presented together with pready
	always_ff @(posedge clk_in) begin
		if (reset_in || por_in) begin
			prdata_out  <= '0;
			pslverr_out <= 1'b0;
		end else if (psel_in && penable_in && !pready_out) begin
			prdata_out  <= pwrite_in ? '0 : next_prdata;
			pslverr_out <= !mapped;
		end else begin
			prdata_out  <= '0;
			pslverr_out <= 1'b0;
		end
	end

	// ==========================================================
	// option decode toward the rest of the chip
	// outputs trail the latches by one clock
	always_ff @(posedge clk_in) begin
		if (reset_in || por_in) begin
			watchdog_enable_out <= 1'b1;
			watchdog_period_out <= `WOR_WDOG_LONG;
			monitor_enable_out  <= 1'b1;
		end else begin
			watchdog_enable_out <= !opt_one[`WOR_ONE_WDOG_OFF];
			watchdog_period_out <= opt_one[`WOR_ONE_WDOG_PERIOD] ?
			                       `WOR_WDOG_SHORT : `WOR_WDOG_LONG;
			monitor_enable_out  <= !opt_one[`WOR_ONE_LV_GUARD_OFF];
		end
	end

	// a reset-pin exit from stop ignores the short recovery choice,
	// which matters when a crystal needs the full settling time
	always_ff @(posedge clk_in) begin
		if (reset_in || por_in) begin
			stop_recovery_out     <= `WOR_STOP_LONG;
			stop_instr_enable_out <= 1'b0;
		end else begin
			stop_recovery_out     <= (opt_one[`WOR_ONE_SHORT_STOP] && !stop_exit_by_reset_in) ?
			                         `WOR_STOP_SHORT : `WOR_STOP_LONG;
			stop_instr_enable_out <= opt_one[`WOR_ONE_STOP_ENABLE];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || por_in) begin
			int_pin_pullup_out   <= 1'b1;
			osc_halt_in_stop_out <= 1'b0;
		end else begin
			int_pin_pullup_out   <= !opt_two[`WOR_TWO_PULLUP_OFF];
			osc_halt_in_stop_out <= opt_two[`WOR_TWO_OSC_OFF];
		end
	end

	// trip level survives a plain reset, so it has no reset term here
	always_ff @(posedge clk_in) begin
		if (por_in) begin
			trip_level_out <= 2'h0;
		end else begin
			trip_level_out <= {opt_two[`WOR_TWO_TRIP_HI], opt_two[`WOR_TWO_TRIP_LO]};
		end
	end

	// oscillator type is untouched by a plain reset
	always_ff @(posedge clk_in) begin
		if (por_in) begin
			crystal_selected_out <= 1'b1;
			shared_pin_free_out  <= 1'b0;
		end else begin
			crystal_selected_out <= (osc_type == WOR_OSC_XTAL);
			shared_pin_free_out  <= (osc_type == WOR_OSC_RC);
		end
	end
endmodule : wor_top
`default_nettype wire

// file: hw/wor_defines.svh
`ifndef WOR_DEFINES_SVH
`define WOR_DEFINES_SVH

// ==========================================================
// register indices and bus widths
`define WOR_IDX_OPT_ONE        8'h1E
`define WOR_IDX_OPT_TWO        8'h1F
`define WOR_IDX_OSC_CHOICE     8'h20
`define WOR_IDX_STATUS         8'h21
`define WOR_ADDR_W             12
`define WOR_DATA_W             32
`define WOR_BYTE_W             8

// ==========================================================
// option word one fields
`define WOR_ONE_WDOG_PERIOD    7
`define WOR_ONE_LV_GUARD_OFF   4
`define WOR_ONE_SHORT_STOP     3
`define WOR_ONE_STOP_ENABLE    1
`define WOR_ONE_WDOG_OFF       0
`define WOR_ONE_MASK           8'h9B

// ==========================================================
// option word two fields
`define WOR_TWO_PULLUP_OFF     7
`define WOR_TWO_TRIP_HI        4
`define WOR_TWO_TRIP_LO        3
`define WOR_TWO_OSC_OFF        0
`define WOR_TWO_MASK           8'h99
`define WOR_TWO_POR_ONLY_MASK  8'h18

// ==========================================================
// oscillator choice byte and status fields
`define WOR_OSC_SEL_BIT        7
`define WOR_OSC_ERASED         8'hFF
`define WOR_STAT_ONE_WRITTEN   0
`define WOR_STAT_TWO_WRITTEN   1
`define WOR_STAT_TRIP_WRITTEN  2
`define WOR_STAT_OSC_VALID     3

// ==========================================================
// reset values and cycle counts
`define WOR_RESET_BYTE         8'h00
`define WOR_WDOG_CNT_W         19
`define WOR_WDOG_SHORT         19'h01FF0
`define WOR_WDOG_LONG          19'h3FFF0
`define WOR_STOP_CNT_W         13
`define WOR_STOP_SHORT         13'h0020
`define WOR_STOP_LONG          13'h1000

`endif

// file: hw/wor_pkg.sv
package wor_pkg;
	typedef enum logic {
		WOR_OSC_RC   = 1'b0,
		WOR_OSC_XTAL = 1'b1
	} wor_osc_t;

	typedef enum logic [1:0] {
		WOR_ACC_NONE  = 2'b00,
		WOR_ACC_READ  = 2'b01,
		WOR_ACC_WRITE = 2'b10
	} wor_acc_t;
endpackage : wor_pkg

// file: hw/wor_once_reg.sv
`timescale 1ns/1ns
`default_nettype none
`include "wor_defines.svh"

module wor_once_reg
	import wor_pkg::*;
#(
	parameter int                 WIDTH     = 8,
	parameter logic [WIDTH-1:0]   USED_MASK = '1,
	parameter logic [WIDTH-1:0]   POR_MASK  = '0
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             por_in,
	input  wire logic             write_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	output logic      [WIDTH-1:0] value_out,
	output logic                  written_out,
	output logic                  por_written_out
);
	// ==========================================================
	// write-once flags
	// por-only bits have their own window that a plain reset never reopens
	always_ff @(posedge clk_in) begin
		if (reset_in || por_in) begin
			written_out <= 1'b0;
		end else if (write_in) begin
			written_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (por_in) begin
			por_written_out <= 1'b0;
		end else if (write_in) begin
			por_written_out <= 1'b1;
		end
	end

	// ==========================================================
	// latches, one per used bit; unused bits read zero
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		if (!USED_MASK[i]) begin : g_unused
			assign value_out[i] = 1'b0;
		end else if (POR_MASK[i]) begin : g_por
			logic bit_q;
			always_ff @(posedge clk_in) begin
				if (por_in) begin
					bit_q <= 1'b0;
				end else if (write_in && !por_written_out) begin
					bit_q <= wdata_in[i];
				end
			end
			assign value_out[i] = bit_q;
		end else begin : g_sys
			logic bit_q;
			always_ff @(posedge clk_in) begin
				if (reset_in || por_in) begin
					bit_q <= 1'b0;
				end else if (write_in && !written_out) begin
					bit_q <= wdata_in[i];
				end
			end
			assign value_out[i] = bit_q;
		end
	end
endmodule : wor_once_reg
`default_nettype wire

// file: hw/wor_osc_capture.sv
`timescale 1ns/1ns
`default_nettype none
`include "wor_defines.svh"

module wor_osc_capture
	import wor_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire logic                   por_in,
	input  wire logic [`WOR_BYTE_W-1:0] flash_byte_in,
	output logic      [`WOR_BYTE_W-1:0] choice_out,
	output wor_osc_t                    osc_type_out,
	output logic                        valid_out
);
	logic por_seen;

	// ==========================================================
	// sample the flash byte once, on the first clock after power-on
	// reset; a plain reset leaves it alone
	always_ff @(posedge clk_in) begin
		if (por_in) begin
			por_seen <= 1'b1;
		end else begin
			por_seen <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (por_in) begin
			valid_out <= 1'b0;
			choice_out <= `WOR_OSC_ERASED;
		end else if (por_seen) begin
			valid_out <= 1'b1;
			choice_out <= flash_byte_in;
		end
	end

	// erased flash reads as one, which means crystal
	assign osc_type_out = wor_osc_t'(choice_out[`WOR_OSC_SEL_BIT]);
endmodule : wor_osc_capture
`default_nettype wire

// file: dv/wor_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "wor_defines.svh"

// ==========================================================
// port checker
module wor_top_properties (
	input wire logic        clk_in, reset_in, por_in, psel_in, penable_in, pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in, prdata_out,
	input wire logic [7:0]  flash_osc_byte_in,
	input wire logic        stop_exit_by_reset_in, pready_out, pslverr_out,
	input wire logic        watchdog_enable_out, monitor_enable_out, stop_instr_enable_out,
	input wire logic        int_pin_pullup_out, osc_halt_in_stop_out,
	input wire logic        crystal_selected_out, shared_pin_free_out,
	input wire logic [18:0] watchdog_period_out,
	input wire logic [1:0]  trip_level_out,
	input wire logic [12:0] stop_recovery_out
);
	wire [7:0] d = prdata_out[7:0];
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in || por_in);
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	// read completing now: prdata shows the latch the outputs decode
	sequence s_rd(a);
		psel_in && penable_in && pready_out && !pwrite_in && paddr_in == a;
	endsequence
	AST_READY: assert property (s_setup |-> ##1 !pready_out ##1 pready_out)
		else $error("ready not two cycles after setup");
	AST_UNMAPPED: assert property (pready_out &&
		!(paddr_in inside {12'h078, 12'h07C, 12'h080, 12'h084}) |-> pslverr_out && d == 8'h00)
		else $error("unmapped access not refused");
	AST_PERIOD: assert property (s_rd(12'h078) |->
		watchdog_period_out == (d[7] ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG))
		else $error("watchdog period differs from word one");
	AST_OPT_ONE: assert property (s_rd(12'h078) |-> monitor_enable_out == !d[4] &&
		stop_instr_enable_out == d[1] && watchdog_enable_out == !d[0])
		else $error("word one enables differ from latch");
	AST_STOP_REC: assert property (s_rd(12'h078) ##0 !stop_exit_by_reset_in &&
		!$past(stop_exit_by_reset_in) |-> stop_recovery_out == (d[3] ? `WOR_STOP_SHORT : `WOR_STOP_LONG))
		else $error("stop recovery differs from word one");
	AST_RST_PIN: assert property (stop_exit_by_reset_in [*2] |-> stop_recovery_out == `WOR_STOP_LONG)
		else $error("reset pin exit not long recovery");
	AST_OPT_TWO: assert property (s_rd(12'h07C) |-> int_pin_pullup_out == !d[7] &&
		trip_level_out == d[4:3] && osc_halt_in_stop_out == d[0])
		else $error("word two outputs differ from latch");
	AST_OSC: assert property (s_rd(12'h080) |->
		crystal_selected_out == d[7] && shared_pin_free_out == !d[7])
		else $error("oscillator outputs differ from choice byte");
	AST_RESET_VAL: assert property (@(posedge clk_in) disable iff (por_in) reset_in |=>
		watchdog_enable_out && monitor_enable_out && int_pin_pullup_out && !stop_instr_enable_out
		&& !osc_halt_in_stop_out && watchdog_period_out == `WOR_WDOG_LONG
		&& stop_recovery_out == `WOR_STOP_LONG)
		else $error("outputs not at reset values");
endmodule : wor_top_properties

bind wor_top wor_top_properties wor_top_properties_i (.clk_in, .reset_in, .por_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .flash_osc_byte_in,
	.stop_exit_by_reset_in, .pready_out, .pslverr_out, .watchdog_enable_out,
	.monitor_enable_out, .stop_instr_enable_out, .int_pin_pullup_out, .osc_halt_in_stop_out,
	.crystal_selected_out, .shared_pin_free_out, .watchdog_period_out, .trip_level_out,
	.stop_recovery_out);
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "wor_defines.svh"

module testbench;
	import wor_pkg::*;
	logic        clk_in = 1'b0, reset_in = 1'b1, por_in = 1'b1, psel_in = 1'b0;
	logic        penable_in = 1'b0, pwrite_in = 1'b0, stop_exit_by_reset_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, q;
	logic [7:0]  flash_osc_byte_in = 8'hFF, v1, v2, t2;
	logic        pready_out, pslverr_out, watchdog_enable_out, monitor_enable_out, e;
	logic        stop_instr_enable_out, int_pin_pullup_out, osc_halt_in_stop_out;
	logic        crystal_selected_out, shared_pin_free_out;
	logic [18:0] watchdog_period_out;
	logic [1:0]  trip_level_out;
	logic [12:0] stop_recovery_out;
	int          num_errors = 0, compares = 0, cycles = 0, seed = 47001;

	always #50 clk_in = ~clk_in;

	wor_top wor_top_i (.clk_in, .reset_in, .por_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .flash_osc_byte_in, .stop_exit_by_reset_in, .prdata_out,
		.pready_out, .pslverr_out, .watchdog_enable_out, .watchdog_period_out,
		.monitor_enable_out, .trip_level_out, .stop_recovery_out, .stop_instr_enable_out,
		.int_pin_pullup_out, .osc_halt_in_stop_out, .crystal_selected_out,
		.shared_pin_free_out);

	// ==========================================================
	// reporting
	task automatic give_verdict;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// ==========================================================
	// bus and reset drivers
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		// upper bits random: they must be ignored
		pwdata_in <= {24'($random(seed)), d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		q = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		check(q, {24'h000000, x});
		check(e, 1'b0);
	endtask : rd

	task automatic pulse(input logic p);
		@(posedge clk_in);
		if (p) por_in <= 1'b1;
		else reset_in <= 1'b1;
		@(posedge clk_in);
		por_in <= 1'b0;
		reset_in <= 1'b0;
		// choice byte capture and oscillator outputs need two edges after release
		repeat (3) @(posedge clk_in);
	endtask : pulse

	// trip pair survives a system reset and stays locked
	function automatic logic [7:0] keep_trip(input logic [7:0] n, input logic [7:0] t);
		return (n & `WOR_TWO_MASK & ~`WOR_TWO_POR_ONLY_MASK) | (t & `WOR_TWO_POR_ONLY_MASK);
	endfunction : keep_trip

	task automatic outs(input logic [7:0] o1, input logic [7:0] o2);
		check(watchdog_period_out, o1[7] ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG);
		check(monitor_enable_out, !o1[4]);
		check(stop_recovery_out, (stop_exit_by_reset_in || !o1[3]) ? `WOR_STOP_LONG
			: `WOR_STOP_SHORT);
		check(stop_instr_enable_out, o1[1]);
		check(watchdog_enable_out, !o1[0]);
		check(int_pin_pullup_out, !o2[7]);
		check(trip_level_out, o2[4:3]);
		check(osc_halt_in_stop_out, o2[0]);
	endtask : outs

	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		por_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		for (int i = 0; i < 4; i++) begin
			if (i > 0) begin
				// low seven bits kept at one, as software is told to
				flash_osc_byte_in <= {(i != 1) & 1'($random(seed)), 7'h7F};
				pulse(1'b1);
			end
			stop_exit_by_reset_in <= (i == 1) | 1'($random(seed));
			rd(12'h080, flash_osc_byte_in);
			check(crystal_selected_out, flash_osc_byte_in[7]);
			check(shared_pin_free_out, !flash_osc_byte_in[7]);
			apb(1'b1, 12'h080, ~flash_osc_byte_in);
			check(e, 1'b0);
			rd(12'h080, flash_osc_byte_in);
			rd(12'h078, 8'h00);
			rd(12'h07C, 8'h00);
			outs(8'h00, 8'h00);
			v1 = 8'($random(seed));
			v2 = (i == 2) ? 8'hFF : 8'($random(seed));
			apb(1'b1, 12'h078, v1);
			apb(1'b1, 12'h078, ~v1);
			rd(12'h078, v1 & `WOR_ONE_MASK);
			apb(1'b1, 12'h07C, v2);
			apb(1'b1, 12'h07C, ~v2);
			rd(12'h07C, v2 & `WOR_TWO_MASK);
			rd(12'h084, 8'h0F);
			outs(v1 & `WOR_ONE_MASK, v2 & `WOR_TWO_MASK);
			pulse(1'b0);
			rd(12'h084, 8'h0C);
			rd(12'h078, 8'h00);
			rd(12'h07C, v2 & `WOR_TWO_POR_ONLY_MASK);
			check(crystal_selected_out, flash_osc_byte_in[7]);
			t2 = 8'($random(seed));
			apb(1'b1, 12'h07C, t2);
			rd(12'h07C, keep_trip(t2, v2));
			outs(8'h00, keep_trip(t2, v2));
		end
		apb(1'b1, 12'h040, 8'h5A);
		check(e, 1'b1);
		apb(1'b0, 12'h07A, 8'h00);
		check(e, 1'b1);
		check(q, 32'h0);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
